/* File: obcd_mem_model.sv */
// memory controller model answering the user memory erase request
`timescale 1ns/1ns
module obcd_mem_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic userEraseReq,
  input wire logic slow,
  output logic userEraseDone
);
  int waitCnt; // cycles spent erasing
  // one-cycle done after a short or a long erase
  always_ff @(posedge clk_sys) begin
    if (rst || !userEraseReq) begin
      waitCnt <= 0;
      userEraseDone <= 1'b0;
    end else begin
      waitCnt <= waitCnt + 1;
      userEraseDone <= (waitCnt == (slow ? 20 : 1));
    end
  end
endmodule : obcd_mem_model

/* File: obcd_nv_store.sv */
// non-volatile option byte store model with erase and program
`timescale 1ns/1ns
module obcd_nv_store (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic progReq, // one-cycle program request
  input wire logic eraseReq, // one-cycle erase request
  input wire logic [7:0] wrByte0,
  input wire logic [7:0] wrByte1,
  output logic [7:0] rdByte0,
  output logic [7:0] rdByte1
);
  // contents survive rst; only erase or program change them
  logic [7:0] cell0Reg = obcd_pkg::OB0_FACTORY;
  logic [7:0] cell1Reg = obcd_pkg::OB1_FACTORY; // internal rc on delivery

  // storage update, erase wins over program
  always_ff @(posedge clk_sys) begin
    if (eraseReq) begin
      cell0Reg <= obcd_pkg::ERASED_BYTE;
      cell1Reg <= obcd_pkg::ERASED_BYTE;
    end else if (progReq) begin
      cell0Reg <= wrByte0;
      cell1Reg <= wrByte1;
    end
  end

  // rst is unused on purpose: the store is non-volatile
  assign rdByte0 = cell0Reg;
  assign rdByte1 = cell1Reg;
endmodule : obcd_nv_store

/* File: obcd_pkg.sv */
// package of option byte layout, register map and timing constants
package obcd_pkg;
  // option byte 0 field positions
  localparam int OB0_HALT_RST_BIT = 7;
  localparam int OB0_WDG_TYPE_BIT = 6;
  localparam int OB0_CSS_N_BIT = 5;
  localparam int OB0_VD_HI = 4;
  localparam int OB0_VD_LO = 3;
  localparam int OB0_RSVD_BIT = 2;
  localparam int OB0_PACKAGE_SEL_BIT_ZERO_BIT = 1;
  localparam int OB0_RDP_N_BIT = 0;
  // option byte 1 field positions
  localparam int OB1_PACKAGE_SEL_BIT_ONE_BIT = 7;
  localparam int OB1_RESET_CYCLE_COUNT_SEL_BIT = 6;
  localparam int OB1_OSC_HI = 5;
  localparam int OB1_OSC_LO = 4;
  localparam int OB1_RNG_HI = 3;
  localparam int OB1_RNG_LO = 1;
  localparam int OB1_PLL_N_BIT = 0;
  // erased storage value
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // factory defaults: internal rc clock selected
  localparam logic [7:0] OB0_FACTORY = 8'hE7;
  localparam logic [7:0] OB1_FACTORY = 8'hEF;
  // voltage detect encodings
  localparam logic [1:0] VD_OFF = 2'h3;
  localparam logic [1:0] VD_LOW = 2'h2;
  localparam logic [1:0] VD_MED = 2'h1;
  localparam logic [1:0] VD_HIGH = 2'h0;
  // clock source encodings
  localparam logic [1:0] OSC_RESONATOR = 2'h0;
  localparam logic [1:0] OSC_RESERVED = 2'h1;
  localparam logic [1:0] OSC_INT_RC = 2'h2;
  localparam logic [1:0] OSC_EXTERNAL = 2'h3;
  // frequency range encodings
  localparam logic [2:0] RNG_1_2 = 3'h0;
  localparam logic [2:0] RNG_2_4 = 3'h1;
  localparam logic [2:0] RNG_4_8 = 3'h2;
  localparam logic [2:0] RNG_8_16 = 3'h3;
  // reset phase lengths in cpu cycles
  localparam int RST_LONG_CYC = 4096;
  localparam int RST_SHORT_CYC = 256;
  // tool register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OB0 = 8'h04;
  localparam logic [7:0] A_OB1 = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_CMD = 8'h10;
  // control and command bits
  localparam int CTRL_PROG_BIT = 0;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_ERASE_BIT = 1;
  // status bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_MEMERASED_BIT = 1;
  localparam int ST_LOADED_BIT = 2;
  // cycles the store takes for one operation
  localparam int NV_OP_CYC = 4;
  localparam int MEM_ERASE_CYC = 16;
endpackage : obcd_pkg

/* File: obcd_props.sv */
// concurrent checks on the option byte decoder ports
`timescale 1ns/1ns
module obcd_props #(
  parameter int LONG_CYC = 4096,
  parameter int SHORT_CYC = 256,
  parameter int PORTS = 6
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic userEraseReq,
  input wire logic userEraseDone,
  input wire logic [PORTS*8-1:0] padBonded,
  input wire logic [PORTS*8-1:0] padForceInput,
  input wire logic [PORTS*8-1:0] padForcePullup,
  input wire logic resetPhaseActive,
  input wire logic reset_cycle_count_sel,
  input wire logic [1:0] voltage_detect_threshold,
  input wire logic low_voltage_detector,
  input wire logic auxiliary_voltage_detector,
  input wire logic halt_entry_reset_sel,
  input wire logic readout_protect_n,
  input wire logic [1:0] clock_source_type,
  input wire logic freq_doubler_disable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  int phaseCnt; // cycles of the running phase
  logic firstPhase; // phase started by reset
  int phaseLen; // expected phase length
  // measure each reset or halt exit phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phaseCnt <= 0;
      firstPhase <= 1'b1;
    end else if (resetPhaseActive) begin
      phaseCnt <= phaseCnt + 1;
    end else begin
      phaseCnt <= 0;
      firstPhase <= 1'b0;
    end
  end
  // small slack, the phase start edge is the designer's choice
  assign phaseLen = reset_cycle_count_sel ? SHORT_CYC : LONG_CYC;
  ready_high_a: assert property (hreadyout) else $error("wait state inserted");
  resp_okay_a: assert property (!hresp) else $error("error response");
  pad_input_a: assert property (padForceInput == ~padBonded) else $error("pad input wrong");
  pad_pullup_a: assert property (padForcePullup == ~padBonded) else $error("pad pullup wrong");
  detect_on_a: assert property (low_voltage_detector == (voltage_detect_threshold != 2'h3))
    else $error("low detector enable wrong");
  aux_detect_a: assert property (auxiliary_voltage_detector == (voltage_detect_threshold != 2'h3))
    else $error("aux detector enable wrong");
  controls_static_a: assert property ((!rst)[*3] |-> $stable({halt_entry_reset_sel, readout_protect_n,
    clock_source_type, freq_doubler_disable, reset_cycle_count_sel, voltage_detect_threshold}))
    else $error("controls changed without reset");
  phase_len_a: assert property ($fell(resetPhaseActive) |-> phaseCnt >= phaseLen - 2 && phaseCnt <= phaseLen + 2)
    else $error("phase length wrong");
  erase_wait_a: assert property (userEraseReq && !userEraseDone |=> userEraseReq)
    else $error("erase request dropped early");
  cover property ($rose(userEraseReq));
  cover property ($fell(resetPhaseActive) && reset_cycle_count_sel && !firstPhase);
  cover property (clock_source_type == 2'h3);
endmodule : obcd_props
bind option_byte_config_decode obcd_props #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC), .PORTS(PORTS)) chk (.*);

/* File: obcd_reset_timer.sv */
// reset phase and halt exit delay counter
`timescale 1ns/1ns
module obcd_reset_timer #(
  parameter int LONG_CYC = obcd_pkg::RST_LONG_CYC,
  parameter int SHORT_CYC = obcd_pkg::RST_SHORT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start, // one-cycle pulse, restarts the count
  input wire logic shortSel, // high selects the short count
  output logic busy // high while the phase runs
);
  localparam int CW = $clog2(LONG_CYC + 1);
  logic [CW-1:0] cntReg; // remaining cycles

  // count down; reset itself starts a phase of the selected length
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cntReg <= shortSel ? CW'(SHORT_CYC) : CW'(LONG_CYC);
    end else if (start) begin
      cntReg <= shortSel ? CW'(SHORT_CYC) : CW'(LONG_CYC);
    end else if (cntReg != '0) begin
      cntReg <= cntReg - CW'(1);
    end
  end

  assign busy = (cntReg != '0);
endmodule : obcd_reset_timer

/* File: option_byte_config_decode.sv */
// option byte loader and decoder with programming-mode tool port on ahb-lite
// Operation
// - option bytes reachable only in programming mode
// - erased storage reads as all ones
// - halt bit one forces reset on halt
// - watchdog type bit zero means hardware watchdog
// - css bit zero enables clock security
// - two bits pick voltage detector threshold
// - package bit zero has no effect
// - protect bit zero blocks readout and writes
// - erase under protection wipes user memory first
// - package bit one selects bonded variant
// - unbonded pads forced input pull-up after reset
// - reset phase bit chooses 4096 or 256
// - two bits select main clock source
// - three bits select frequency range
// - doubler bit zero enables x2 pll
// - factory contents select internal rc clock
`timescale 1ns/1ns
module option_byte_config_decode #(
  parameter int LONG_CYC = obcd_pkg::RST_LONG_CYC, // long reset phase
  parameter int SHORT_CYC = obcd_pkg::RST_SHORT_CYC, // short reset phase
  parameter int PORTS = 6 // number of i/o ports of eight pads
) (
  input wire logic clk_sys,
  input wire logic rst,
  // programming tool port, ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // user memory erase handshake
  output logic userEraseReq,
  input wire logic userEraseDone,
  // bonding map: one bit per pad, high where bonded
  input wire logic [PORTS*8-1:0] padBonded,
  output logic [PORTS*8-1:0] padForceInput,
  output logic [PORTS*8-1:0] padForcePullup,
  // decoded controls
  output logic resetPhaseActive,
  input wire logic haltExitStart,
  output logic halt_entry_reset_sel,
  output logic watchdog_type_sel,
  output logic clock_security_enable_n,
  output logic [1:0] voltage_detect_threshold,
  output logic low_voltage_detector,
  output logic auxiliary_voltage_detector,
  output logic package_sel_bit_one,
  output logic readout_protect_n,
  output logic reset_cycle_count_sel,
  output logic [1:0] clock_source_type,
  output logic [2:0] clock_frequency_range,
  output logic freq_doubler_disable
);
  typedef enum {OBCD_IDLE, OBCD_MEMERASE, OBCD_NVOP} obcd_state_t;

  obcd_state_t stateReg; // store operation sequencer
  logic [7:0] ob0Reg; // loaded option byte 0
  logic [7:0] ob1Reg; // loaded option byte 1
  logic [7:0] stage0Reg; // tool staging byte 0
  logic [7:0] stage1Reg; // tool staging byte 1
  logic progModeReg; // programming mode enable
  logic memErasedReg; // sticky: user memory wiped
  logic loadedReg; // bytes captured this reset
  logic eraseOpReg; // pending op is an erase
  logic [4:0] opCntReg; // operation cycle counter
  logic [7:0] nvByte0; // store read data
  logic [7:0] nvByte1;
  logic nvProg; // store program pulse
  logic nvErase; // store erase pulse
  logic timerStart; // restart phase timer
  logic shortPhase; // phase length choice for the timer
  // ahb address phase capture
  logic dpWrReg;
  logic dpRdReg;
  logic [7:0] dpAddrReg;
  logic addrPhase;
  logic busy;

  // reports a register hit for a given byte address
  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] ref_a);
    isAddr = (a == ref_a);
  endfunction : isAddr

  obcd_nv_store uStore (
    .clk_sys(clk_sys),
    .rst(rst),
    .progReq(nvProg),
    .eraseReq(nvErase),
    .wrByte0(stage0Reg),
    .wrByte1(stage1Reg),
    .rdByte0(nvByte0),
    .rdByte1(nvByte1)
  );

  obcd_reset_timer #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC)
  ) uTimer (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(timerStart),
    .shortSel(shortPhase),
    .busy(resetPhaseActive)
  );

  // the halt exit delay reuses the same counter and length choice
  assign timerStart = haltExitStart & ~resetPhaseActive;
  // during reset the store is read directly, so the reset phase itself already has the chosen length
  assign shortPhase = rst ? nvByte1[obcd_pkg::OB1_RESET_CYCLE_COUNT_SEL_BIT] : ob1Reg[obcd_pkg::OB1_RESET_CYCLE_COUNT_SEL_BIT];

  // slave always ready and always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel & hready & htrans[1];
  assign busy = (stateReg != OBCD_IDLE);

  // address phase capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dpWrReg <= 1'b0;
      dpRdReg <= 1'b0;
      dpAddrReg <= 8'h00;
    end else if (hready) begin
      dpWrReg <= addrPhase & hwrite;
      dpRdReg <= addrPhase & ~hwrite;
      dpAddrReg <= haddr;
    end
  end

  // programming mode flag, the only register writable outside programming mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      progModeReg <= 1'b0;
    end else if (dpWrReg && isAddr(dpAddrReg, obcd_pkg::A_CTRL)) begin
      progModeReg <= hwdata[obcd_pkg::CTRL_PROG_BIT];
    end
  end

  // staging bytes: writes ignored unless in programming mode and idle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage0Reg <= obcd_pkg::ERASED_BYTE;
      stage1Reg <= obcd_pkg::ERASED_BYTE;
    end else if (dpWrReg && progModeReg && !busy) begin
      if (isAddr(dpAddrReg, obcd_pkg::A_OB0)) begin
        stage0Reg <= hwdata[7:0]; // reserved bit kept by the tool
      end
      if (isAddr(dpAddrReg, obcd_pkg::A_OB1)) begin
        stage1Reg <= hwdata[7:0];
      end
    end
  end

  // store sequencer: protected erase wipes user memory before the bytes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stateReg <= OBCD_IDLE;
      eraseOpReg <= 1'b0;
      opCntReg <= 5'h00;
    end else begin
      case (stateReg)
        OBCD_IDLE: begin
          opCntReg <= 5'h00;
          if (dpWrReg && progModeReg && isAddr(dpAddrReg, obcd_pkg::A_CMD)) begin
            if (hwdata[obcd_pkg::CMD_ERASE_BIT]) begin
              eraseOpReg <= 1'b1;
              // protection active: user memory goes first
              stateReg <= ob0Reg[obcd_pkg::OB0_RDP_N_BIT] ? OBCD_NVOP : OBCD_MEMERASE;
            end else if (hwdata[obcd_pkg::CMD_WRITE_BIT]) begin
              // protected parts refuse programming until erased
              if (ob0Reg[obcd_pkg::OB0_RDP_N_BIT] || memErasedReg) begin
                eraseOpReg <= 1'b0;
                stateReg <= OBCD_NVOP;
              end
            end
          end
        end
        OBCD_MEMERASE: begin
          // wait for the memory controller; no timeout here
          if (userEraseDone) begin
            stateReg <= OBCD_NVOP;
          end
        end
        OBCD_NVOP: begin
          opCntReg <= opCntReg + 5'h01;
          if (opCntReg == 5'(obcd_pkg::NV_OP_CYC - 1)) begin
            stateReg <= OBCD_IDLE;
          end
        end
        default: begin
          stateReg <= OBCD_IDLE;
        end
      endcase
    end
  end

  assign userEraseReq = (stateReg == OBCD_MEMERASE);
  assign nvErase = (stateReg == OBCD_NVOP) && eraseOpReg && (opCntReg == 5'h00);
  assign nvProg = (stateReg == OBCD_NVOP) && !eraseOpReg && (opCntReg == 5'h00);

  // sticky record that user memory was wiped; reset wins over set and is the only clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      memErasedReg <= 1'b0;
    end else if (stateReg == OBCD_MEMERASE && userEraseDone) begin
      memErasedReg <= 1'b1;
    end
  end

  // capture the store once per reset, then freeze until the next reset;
  // a later program only takes effect after reset, so controls stay static
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ob0Reg <= obcd_pkg::OB0_FACTORY;
      ob1Reg <= obcd_pkg::OB1_FACTORY;
      loadedReg <= 1'b0;
    end else if (!loadedReg) begin
      ob0Reg <= nvByte0;
      ob1Reg <= nvByte1;
      loadedReg <= 1'b1;
    end
  end

  // read data: option bytes visible only in programming mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= 32'h00000000;
      if (isAddr(haddr, obcd_pkg::A_CTRL)) begin
        hrdata[obcd_pkg::CTRL_PROG_BIT] <= progModeReg;
      end else if (isAddr(haddr, obcd_pkg::A_OB0) && progModeReg) begin
        hrdata[7:0] <= nvByte0;
      end else if (isAddr(haddr, obcd_pkg::A_OB1) && progModeReg) begin
        hrdata[7:0] <= nvByte1;
      end else if (isAddr(haddr, obcd_pkg::A_STAT)) begin
        hrdata[obcd_pkg::ST_BUSY_BIT] <= busy;
        hrdata[obcd_pkg::ST_MEMERASED_BIT] <= memErasedReg;
        hrdata[obcd_pkg::ST_LOADED_BIT] <= loadedReg;
      end
    end
  end

  // decoded controls, straight from the loaded bytes
  assign halt_entry_reset_sel = ob0Reg[obcd_pkg::OB0_HALT_RST_BIT];
  assign watchdog_type_sel = ob0Reg[obcd_pkg::OB0_WDG_TYPE_BIT];
  assign clock_security_enable_n = ob0Reg[obcd_pkg::OB0_CSS_N_BIT];
  assign voltage_detect_threshold = ob0Reg[obcd_pkg::OB0_VD_HI:obcd_pkg::OB0_VD_LO];
  // both detectors share the enable; off code disables both
  assign low_voltage_detector = (voltage_detect_threshold != obcd_pkg::VD_OFF);
  assign auxiliary_voltage_detector = (voltage_detect_threshold != obcd_pkg::VD_OFF);
  // package bit zero deliberately drives nothing
  assign readout_protect_n = ob0Reg[obcd_pkg::OB0_RDP_N_BIT];
  assign package_sel_bit_one = ob1Reg[obcd_pkg::OB1_PACKAGE_SEL_BIT_ONE_BIT];
  assign reset_cycle_count_sel = ob1Reg[obcd_pkg::OB1_RESET_CYCLE_COUNT_SEL_BIT];
  assign clock_source_type = ob1Reg[obcd_pkg::OB1_OSC_HI:obcd_pkg::OB1_OSC_LO];
  assign clock_frequency_range = ob1Reg[obcd_pkg::OB1_RNG_HI:obcd_pkg::OB1_RNG_LO];
  // pll use is the tool's care: rc source or wrong range is not blocked
  assign freq_doubler_disable = ob1Reg[obcd_pkg::OB1_PLL_N_BIT];

  // pad forcing, one lane per pad
  genvar gi;
  generate
    for (gi = 0; gi < PORTS * 8; gi++) begin : g_pad
      // unbonded pads held as pulled-up inputs from reset on
      assign padForceInput[gi] = ~padBonded[gi];
      assign padForcePullup[gi] = ~padBonded[gi];
    end
  endgenerate
  // factory store content selects internal rc long phase advice is the tool's
endmodule : option_byte_config_decode

/* File: option_byte_config_decode_test.sv */
// self-checking bench for the option byte decoder
`timescale 1ns/1ns
module option_byte_config_decode_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // whole words only
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, userEraseReq, userEraseDone, resetPhaseActive;
  logic [31:0] hrdata;
  logic [47:0] padBonded = 48'h0;
  logic [47:0] padForceInput, padForcePullup;
  logic haltExitStart = 1'b0;
  logic slow = 1'b0; // erase answer speed
  logic halt_entry_reset_sel, watchdog_type_sel, clock_security_enable_n, low_voltage_detector;
  logic auxiliary_voltage_detector, package_sel_bit_one, readout_protect_n, reset_cycle_count_sel;
  logic freq_doubler_disable;
  logic [1:0] voltage_detect_threshold, clock_source_type;
  logic [2:0] clock_frequency_range;
  int failures = 0;
  int checks = 0;
  logic [31:0] qRd[$]; // expected read data
  logic [13:0] qDec[$]; // expected decoded controls
  logic rdChk = 1'b0; // current read is compared
  logic rdPend = 1'b0; // compared read in data phase
  event evDec;
  logic [13:0] dec; // decoded controls, option bit order
  assign dec = {halt_entry_reset_sel, watchdog_type_sel, clock_security_enable_n, voltage_detect_threshold,
    readout_protect_n, package_sel_bit_one, reset_cycle_count_sel, clock_source_type, clock_frequency_range,
    freq_doubler_disable};
  assign hready = hreadyout; // single slave
  option_byte_config_decode #(.LONG_CYC(64), .SHORT_CYC(16)) uut (.*);
  obcd_mem_model mem (.clk_sys, .rst, .userEraseReq, .slow, .userEraseDone);
  // clock at 50 mhz
  always #10 clk_sys = ~clk_sys;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // read data checked one edge after its address phase
  always @(posedge clk_sys) begin
    if (rdPend && hreadyout === 1'b1) cmp(hrdata, qRd.pop_front());
    rdPend <= hsel && htrans[1] && !hwrite && rdChk && hreadyout;
  end
  // decoded controls checked on request
  always @(evDec) cmp({18'h0, dec}, {18'h0, qDec.pop_front()});
  task automatic waitRdy();
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask : waitRdy
  task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    r = hrdata;
    rdChk <= 1'b0;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    qRd.push_back(e);
    rdChk <= 1'b1;
    ahb(a, 1'b0, 32'h0, r);
  endtask : rd
  // wait for the store to go idle
  task automatic poll();
    logic [31:0] r;
    r = 32'h1;
    for (int n = 0; n < 200 && r[0] !== 1'b0; n++) ahb(8'h0C, 1'b0, 32'h0, r);
    if (r[0] !== 1'b0) begin
      failures++;
      $display("mismatch at %0t: store stays busy", $time);
    end
  endtask : poll
  task automatic chkDec(input logic [15:0] v);
    #1;
    qDec.push_back({v[15:11], v[8], v[7:0]});
    ->evDec;
  endtask : chkDec
  task automatic waitPhase();
    repeat (2) @(posedge clk_sys);
    for (int k = 0; k < 300 && resetPhaseActive !== 1'b0; k++) @(posedge clk_sys);
    if (resetPhaseActive !== 1'b0) begin
      failures++;
      $display("mismatch at %0t: phase never ended", $time);
    end
  endtask : waitPhase
  task automatic doReset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk_sys);
    rst <= 1'b0;
    waitPhase();
  endtask : doReset
  // halt exit reuses the reset phase length
  task automatic haltExit();
    haltExitStart <= 1'b1;
    @(posedge clk_sys);
    haltExitStart <= 1'b0;
    waitPhase();
  endtask : haltExit
  // random option bytes the tool may legally program
  function automatic logic [15:0] pick(input int i);
    logic [7:0] b0, b1;
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    b0[4:3] = i[1:0];
    b0[2] = 1'b1;
    b0[0] = 1'b1; // unprotected
    b1[5:4] = i[1:0];
    b1[3:1] = i[2:0];
    if (i == 3) b1[6] = 1'b1;
    if (b1[5:4] == 2'h0) b1[6] = 1'b0;
    if (b1[3:1] != 3'h1 || b1[5:4] == 2'h2) b1[0] = 1'b1;
    return {b0, b1};
  endfunction : pick
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // hang guard, tests take well under 100 us
  initial begin
    #400000;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
  // main sequence
  initial begin
    logic [15:0] cur, v;
    void'($urandom(32'h5BB7));
    padBonded <= {16'($urandom), $urandom};
    doReset(16);
    chkDec(16'hE7EF);
    rd(8'h04, 32'h0);
    rd(8'h14, 32'h0);
    cur = 16'hE7EF;
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      v = pick(i);
      padBonded <= {16'($urandom), $urandom};
      wr(8'h00, 32'h1);
      rd(8'h08, {24'h0, cur[7:0]});
      wr(8'h04, {24'h0, v[15:8]});
      wr(8'h08, {24'h0, v[7:0]});
      wr(8'h10, 32'h1);
      poll();
      rd(8'h04, {24'h0, v[15:8]});
      chkDec(cur);
      doReset(2);
      chkDec(v);
      haltExit();
      cur = v;
    end
    $display("test decode done");
    wr(8'h00, 32'h1);
    wr(8'h04, 32'hE6);
    wr(8'h08, {24'h0, cur[7:0]});
    wr(8'h10, 32'h1);
    poll();
    doReset(2);
    chkDec({8'hE6, cur[7:0]});
    wr(8'h00, 32'h1);
    wr(8'h04, 32'hE7);
    wr(8'h10, 32'h1);
    poll();
    rd(8'h04, 32'hE6);
    slow <= 1'b1;
    wr(8'h10, 32'h2);
    poll();
    rd(8'h04, 32'hFF);
    rd(8'h08, 32'hFF);
    rd(8'h0C, 32'h6);
    doReset(2);
    chkDec(16'hFFFF);
    $display("test protect erase done");
    repeat (2) @(posedge clk_sys);
    end_of_test();
  end
endmodule : option_byte_config_decode_test
